// ### hdl/fpq_map.svh
// Purpose: opcodes, field positions and constants of the store unit
// Assumes: instruction bit 0 is the least significant bit of the word
// Notes:   instruction field macros are bit ranges of a 32-bit instruction word; conversion field macros are bit ranges of a double
//
// Contract
// RL1 - opcode 60, sub 00: paired displacement store
// RL2 - opcode 61, sub 01: paired update store
// RL3 - 14-bit displacement used only for address
// RL4 - sign-extend to 30 bits, append 00
// RL5 - zero base: offset alone, else add base
// RL6 - opcode 31, xo 951/919: paired indexed stores
// RL7 - indexed address: base plus index, base nonzero
// RL8 - zero base: index alone, no register zero read
// RL9 - source at address, next register at plus eight
// RL10 - source 31 pairs with register 0
// RL11 - update forms write address back, nonzero base
// RL12 - status register and condition field untouched
// RL13 - opcode 52: single displacement store fields
// RL14 - single: sign-extend 16-bit displacement, add base
// RL15 - single zero base: displacement alone, no update
// RL16 - single: convert double to single, store word
// RL17 - big-endian stores, first before second, stall
`ifndef FPQ_MAP_SVH
`define FPQ_MAP_SVH

////////////////////////////////////////////////////////////////////////
// instruction fields
`define FPQ_OPCD_F 31:26
`define FPQ_FRS_F 25:21
`define FPQ_RA_F 20:16
`define FPQ_RB_F 15:11
`define FPQ_DS_F 15:2
`define FPQ_SUB_F 1:0
`define FPQ_XO_F 10:1
`define FPQ_D_F 15:0
`define FPQ_SIGN_BIT 15

////////////////////////////////////////////////////////////////////////
// opcodes
`define FPQ_OP_PAIR_D 6'h3c
`define FPQ_OP_PAIR_DU 6'h3d
`define FPQ_OP_EXT 6'h1f
`define FPQ_OP_SGL_D 6'h34
`define FPQ_SUB_D 2'h0
`define FPQ_SUB_DU 2'h1
`define FPQ_XO_PAIR_XU 10'h3b7
`define FPQ_XO_PAIR_X 10'h397
`define FPQ_WORD_ALIGN 2'h0

////////////////////////////////////////////////////////////////////////
// addressing and store port
`define FPQ_REG_ZERO 5'h00
`define FPQ_REG_STEP 5'h01
`define FPQ_DW_STEP 32'h0000_0008
`define FPQ_BE_DWORD 8'hff
`define FPQ_BE_WORD 8'hf0
`define FPQ_LOW_WORD 32'h0000_0000

////////////////////////////////////////////////////////////////////////
// double to single conversion
`define FPQ_EXP_F 62:52
`define FPQ_FRAC_F 51:0
`define FPQ_HI2_F 63:62
`define FPQ_MID_F 58:29
`define FPQ_SHFRAC_F 51:29
`define FPQ_EXP_NORM 11'h381
`define FPQ_EXP_DENORM 11'h36a
`define FPQ_SGL_ZEXP 8'h00

`endif

// ### hdl/fpq_pkg.sv
// Purpose: types shared by the store unit modules
// Assumes: nothing
// Notes:   decoded instruction and controller state types
package fpq_pkg;

   typedef enum logic [2:0] {
      K_NONE = 3'h0,
      K_PAIR_D = 3'h1,
      K_PAIR_DU = 3'h2,
      K_PAIR_XU = 3'h3,
      K_PAIR_X = 3'h4,
      K_SGL_D = 3'h5
   } kind_t;

   typedef struct packed {
      kind_t kind;
      logic pair;
      logic update;
      logic indexed;
      logic [4:0] fp_source_reg;
      logic [4:0] base_reg_field;
      logic [4:0] index_reg_field;
      logic [31:0] offset;
   } dec_t;

   typedef enum logic [6:0] {
      S_IDLE = 7'b000_0001,
      S_ADDR = 7'b000_0010,
      S_LOAD0 = 7'b000_0100,
      S_SEND0 = 7'b000_1000,
      S_LOAD1 = 7'b001_0000,
      S_SEND1 = 7'b010_0000,
      S_DONE = 7'b100_0000
   } state_t;

endpackage : fpq_pkg

// ### hdl/fpq_dec_if.sv
// Purpose: carries an instruction word to the decoder and back
// Assumes: decode is purely combinational
// Notes:   one modport per side
`timescale 1ns/1ps
interface fpq_dec_if;
   logic [31:0] instr;
   fpq_pkg::dec_t dec;
   modport dcd (input instr, output dec);
   modport core (output instr, input dec);
endinterface : fpq_dec_if

// ### hdl/fpq_decode.sv
// Purpose: decodes the paired and single floating-point stores
// Assumes: instruction word is stable while decoded
// Notes:   unknown encodings decode as K_NONE; record bit ignored
`timescale 1ns/1ps
`include "fpq_map.svh"
module fpq_decode (
   // decode channel
   fpq_dec_if.dcd dif
);

   fpq_pkg::dec_t d;
   logic [31:0] w;

   always_comb begin
      w = dif.instr;
      d = '0;
      d.kind = fpq_pkg::K_NONE;
      d.fp_source_reg = w[`FPQ_FRS_F];
      d.base_reg_field = w[`FPQ_RA_F];
      d.index_reg_field = w[`FPQ_RB_F];
      // word displacement, only feeds the address [RL3] [RL4]
      d.offset = {{16{w[`FPQ_SIGN_BIT]}}, w[`FPQ_DS_F], `FPQ_WORD_ALIGN};
      case (w[`FPQ_OPCD_F])
         `FPQ_OP_PAIR_D: begin
            if (w[`FPQ_SUB_F] == `FPQ_SUB_D) begin
               d.kind = fpq_pkg::K_PAIR_D; // [RL1]
            end
         end
         `FPQ_OP_PAIR_DU: begin
            if (w[`FPQ_SUB_F] == `FPQ_SUB_DU) begin
               d.kind = fpq_pkg::K_PAIR_DU; // [RL2]
               d.update = 1'b1;
            end
         end
         `FPQ_OP_EXT: begin
            d.indexed = 1'b1;
            if (w[`FPQ_XO_F] == `FPQ_XO_PAIR_XU) begin
               d.kind = fpq_pkg::K_PAIR_XU; // [RL6]
               d.update = 1'b1;
            end else if (w[`FPQ_XO_F] == `FPQ_XO_PAIR_X) begin
               d.kind = fpq_pkg::K_PAIR_X; // [RL6]
            end
         end
         `FPQ_OP_SGL_D: begin
            d.kind = fpq_pkg::K_SGL_D; // [RL13]
            d.offset = {{16{w[`FPQ_SIGN_BIT]}}, w[`FPQ_D_F]}; // [RL14]
         end
         default: begin
            d.kind = fpq_pkg::K_NONE;
         end
      endcase
      d.pair = (d.kind != fpq_pkg::K_NONE) && (d.kind != fpq_pkg::K_SGL_D);
      dif.dec = d;
   end

endmodule : fpq_decode

// ### hdl/fp_quad_single_store_exec.sv
// Purpose: executes paired doubleword and single word fp stores
// Assumes: register file reads return data in the same cycle
// Notes:   one instruction at a time; stalls on the store port
`timescale 1ns/1ps
`include "fpq_map.svh"
module fp_quad_single_store_exec (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,

   // instruction issue
   input wire logic i_instr_valid,
   input wire logic [31:0] i_instr,
   output logic o_instr_ready,
   output logic o_busy,
   output logic o_done,
   output logic o_unsupported,

   // general register read ports
   output logic o_gpr_a_rd,
   output logic [4:0] o_gpr_a_idx,
   input wire logic [31:0] i_gpr_a_data,
   output logic o_gpr_b_rd,
   output logic [4:0] o_gpr_b_idx,
   input wire logic [31:0] i_gpr_b_data,

   // floating-point register read port
   output logic o_fpr_rd,
   output logic [4:0] o_fpr_idx,
   input wire logic [63:0] i_fpr_data,

   // general register write-back
   output logic o_gpr_we,
   output logic [4:0] o_gpr_w_idx,
   output logic [31:0] o_gpr_w_data,

   // data memory store port
   output logic o_st_valid,
   input wire logic i_st_ready,
   output logic [31:0] o_st_addr,
   output logic [63:0] o_st_data,
   output logic [7:0] o_st_be,
   output logic o_st_dword
);

   ////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      fpq_pkg::state_t state;
      fpq_pkg::dec_t dec;
      logic [31:0] ea;
      logic st_valid;
      logic [31:0] st_addr;
      logic [63:0] st_data;
      logic [7:0] st_be;
      logic st_dword;
      logic wb_we;
      logic [4:0] wb_idx;
      logic [31:0] wb_data;
      logic done;
      logic unsup;
   } st_t;

   st_t q;
   st_t n;

   ////////////////////////////////////////////////////////////////////
   // decoder

   fpq_dec_if dif ();

   assign dif.instr = i_instr;

   fpq_decode u_decode (
      .dif(dif)
   );

   ////////////////////////////////////////////////////////////////////
   // helpers

   // effective address of all five forms
   function automatic logic [31:0] ea_calc(
      input logic [4:0] base_idx,
      input logic [31:0] base_val,
      input logic indexed,
      input logic [31:0] index_val,
      input logic [31:0] offset
   );
      logic [31:0] base_term;
      logic [31:0] add_term;
      begin
         if (base_idx == `FPQ_REG_ZERO) begin
            base_term = '0; // [RL5] [RL8] [RL15]
         end else begin
            base_term = base_val; // [RL5] [RL7] [RL14]
         end
         if (indexed) begin
            add_term = index_val; // [RL7]
         end else begin
            add_term = offset;
         end
         ea_calc = base_term + add_term;
      end
   endfunction : ea_calc

   // second register of a pair wraps from 31 to 0
   function automatic logic [4:0] pair_next(input logic [4:0] idx);
      begin
         pair_next = 5'(idx + `FPQ_REG_STEP); // [RL10]
      end
   endfunction : pair_next

   // double format to single format word
   function automatic logic [31:0] to_single(input logic [63:0] d);
      logic [10:0] exp;
      logic [52:0] mant;
      logic [52:0] shifted;
      logic [4:0] shamt;
      begin
         exp = d[`FPQ_EXP_F];
         mant = {1'b1, d[`FPQ_FRAC_F]};
         shamt = 5'(`FPQ_EXP_NORM - exp);
         shifted = mant >> shamt;
         if ((exp < `FPQ_EXP_NORM) && (exp >= `FPQ_EXP_DENORM)) begin
            to_single = {d[63], `FPQ_SGL_ZEXP, shifted[`FPQ_SHFRAC_F]};
         end else begin
            to_single = {d[`FPQ_HI2_F], d[`FPQ_MID_F]};
         end
      end
   endfunction : to_single

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      n = q;
      n.done = 1'b0;
      n.unsup = 1'b0;
      n.wb_we = 1'b0;
      case (q.state)
         fpq_pkg::S_IDLE: begin
            if (i_instr_valid) begin
               if (dif.dec.kind != fpq_pkg::K_NONE) begin
                  n.dec = dif.dec;
                  n.state = fpq_pkg::S_ADDR;
               end else begin
                  n.unsup = 1'b1;
               end
            end
         end
         fpq_pkg::S_ADDR: begin
            n.ea = ea_calc(q.dec.base_reg_field, i_gpr_a_data,
                           q.dec.indexed, i_gpr_b_data, q.dec.offset);
            n.state = fpq_pkg::S_LOAD0;
         end
         fpq_pkg::S_LOAD0: begin
            n.st_valid = 1'b1;
            n.st_addr = q.ea;
            if (q.dec.pair) begin
               n.st_data = i_fpr_data; // [RL9] [RL17]
               n.st_be = `FPQ_BE_DWORD;
               n.st_dword = 1'b1;
            end else begin
               n.st_data = {to_single(i_fpr_data), `FPQ_LOW_WORD}; // [RL16]
               n.st_be = `FPQ_BE_WORD; // [RL17]
               n.st_dword = 1'b0;
            end
            n.state = fpq_pkg::S_SEND0;
         end
         fpq_pkg::S_SEND0: begin
            if (i_st_ready) begin
               n.st_valid = 1'b0;
               if (q.dec.pair) begin
                  n.state = fpq_pkg::S_LOAD1; // [RL17]
               end else begin
                  n.state = fpq_pkg::S_DONE;
                  n.done = 1'b1;
               end
            end
         end
         fpq_pkg::S_LOAD1: begin
            n.st_valid = 1'b1;
            n.st_addr = q.ea + `FPQ_DW_STEP; // [RL9]
            n.st_data = i_fpr_data; // [RL9]
            n.st_be = `FPQ_BE_DWORD;
            n.st_dword = 1'b1;
            n.state = fpq_pkg::S_SEND1;
         end
         fpq_pkg::S_SEND1: begin
            if (i_st_ready) begin
               n.st_valid = 1'b0;
               n.state = fpq_pkg::S_DONE;
               n.done = 1'b1;
               // only the base register is written back [RL11] [RL12]
               n.wb_we = q.dec.update &&
                         (q.dec.base_reg_field != `FPQ_REG_ZERO);
               n.wb_idx = q.dec.base_reg_field;
               n.wb_data = q.ea;
            end
         end
         fpq_pkg::S_DONE: begin
            n.state = fpq_pkg::S_IDLE;
         end
         default: begin
            n.state = fpq_pkg::S_IDLE;
            n.st_valid = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
         q.state <= fpq_pkg::S_IDLE;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign o_instr_ready = (q.state == fpq_pkg::S_IDLE);
   assign o_busy = (q.state != fpq_pkg::S_IDLE);
   assign o_done = q.done;
   assign o_unsupported = q.unsup;

   // zero base is never read [RL8]
   assign o_gpr_a_rd = (q.state == fpq_pkg::S_ADDR) &&
                       (q.dec.base_reg_field != `FPQ_REG_ZERO);
   assign o_gpr_a_idx = q.dec.base_reg_field;
   assign o_gpr_b_rd = (q.state == fpq_pkg::S_ADDR) && q.dec.indexed;
   assign o_gpr_b_idx = q.dec.index_reg_field;

   assign o_fpr_rd = (q.state == fpq_pkg::S_LOAD0) ||
                     (q.state == fpq_pkg::S_LOAD1);
   assign o_fpr_idx = (q.state == fpq_pkg::S_LOAD1) ?
                      pair_next(q.dec.fp_source_reg) : // [RL10]
                      q.dec.fp_source_reg;

   assign o_gpr_we = q.wb_we; // [RL11] [RL15]
   assign o_gpr_w_idx = q.wb_idx;
   assign o_gpr_w_data = q.wb_data;

   assign o_st_valid = q.st_valid; // [RL17]
   assign o_st_addr = q.st_addr;
   assign o_st_data = q.st_data;
   assign o_st_be = q.st_be;
   assign o_st_dword = q.st_dword;

endmodule : fp_quad_single_store_exec

// ### tb/store_exec_checker.sv
// Purpose: port checks of the fp store unit
// Assumes: one clock, reset active low
// Notes:   store port stalls stay short
`timescale 1ns/1ps
module store_exec_checker (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // issue
   input wire logic i_instr_valid,
   input wire logic o_instr_ready,
   input wire logic o_done,
   input wire logic o_unsupported,
   // register ports
   input wire logic o_gpr_a_rd,
   input wire logic [4:0] o_gpr_a_idx,
   input wire logic o_fpr_rd,
   input wire logic [4:0] o_fpr_idx,
   input wire logic o_gpr_we,
   input wire logic [4:0] o_gpr_w_idx,
   input wire logic [31:0] o_gpr_w_data,
   // store port
   input wire logic o_st_valid,
   input wire logic i_st_ready,
   input wire logic [31:0] o_st_addr,
   input wire logic [63:0] o_st_data,
   input wire logic [7:0] o_st_be,
   input wire logic o_st_dword
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   ///////////////////////////////////////////////////////////
   // last fp register read
   logic [4:0] rd_idx_q;
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) rd_idx_q <= 5'h00;
      else if (o_fpr_rd) rd_idx_q <= o_fpr_idx;
   end
   sequence take_s; i_instr_valid && o_instr_ready; endsequence
   sequence first_acc_s; o_st_valid && i_st_ready && o_st_dword; endsequence
   sequence second_rd_s; first_acc_s ##1 o_fpr_rd; endsequence
   take_done_a: assert property (take_s |=> o_unsupported or ##[2:60] o_done)
      else $error("instruction did not finish");
   fpr_wrap_a: assert property (second_rd_s |-> o_fpr_idx == rd_idx_q + 5'h01)
      else $error("second register index wrong");
   pair_addr_a: assert property (second_rd_s |=>
      o_st_valid && o_st_addr == $past(o_st_addr, 2) + 32'h0000_0008)
      else $error("second store address wrong");
   st_hold_a: assert property (o_st_valid && !i_st_ready |=>
      o_st_valid && $stable(o_st_addr) && $stable(o_st_data))
      else $error("store request changed while stalled");
   st_drop_a: assert property (o_st_valid && i_st_ready |=> !o_st_valid)
      else $error("store request not released");
   done_pulse_a: assert property (o_done |=> !o_done && o_instr_ready)
      else $error("done not a single pulse");
   wb_addr_a: assert property (o_gpr_we |-> o_done && o_gpr_w_idx != 5'h00
      && o_gpr_w_data == $past(o_st_addr) - 32'h0000_0008)
      else $error("write-back wrong");
   base_zero_a: assert property (o_gpr_a_rd |-> o_gpr_a_idx != 5'h00)
      else $error("register zero read");
   word_form_a: assert property (o_st_valid && !o_st_dword |->
      o_st_be == 8'hf0 && o_st_data[31:0] == 32'h0000_0000)
      else $error("word store format wrong");
   dword_be_a: assert property (o_st_valid && o_st_dword |-> o_st_be == 8'hff)
      else $error("doubleword enables wrong");
endmodule : store_exec_checker
bind fp_quad_single_store_exec store_exec_checker store_exec_checker_inst (.*);

// ### tb/store_port_model.sv
// Purpose: register files and store port beside the store unit
// Assumes: reads answer in the cycle of the strobe
// Notes:   ready held low for i_stall cycles per request
`timescale 1ns/1ps
module store_port_model (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // stall control
   input wire logic [1:0] i_stall,
   // register reads
   input wire logic i_gpr_a_rd,
   input wire logic [4:0] i_gpr_a_idx,
   input wire logic i_gpr_b_rd,
   input wire logic [4:0] i_gpr_b_idx,
   input wire logic i_fpr_rd,
   input wire logic [4:0] i_fpr_idx,
   output logic [31:0] o_gpr_a_data,
   output logic [31:0] o_gpr_b_data,
   output logic [63:0] o_fpr_data,
   // store port
   input wire logic i_st_valid,
   output logic o_st_ready
);
   logic [1:0] wait_q;
   logic [31:0] noise_q;
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_q <= 2'h0;
         noise_q <= 32'h0000_0000;
      end else begin
         noise_q <= noise_q + 32'h9e37_79b9;
         wait_q <= (i_st_valid && !o_st_ready) ? wait_q + 2'h1 : 2'h0;
      end
   end
   // accept once the stall has run out
   assign o_st_ready = i_st_valid && (wait_q == i_stall);
   // unread lines change every cycle
   assign o_gpr_a_data = i_gpr_a_rd ? {11'h0, i_gpr_a_idx, 16'h0} : noise_q;
   assign o_gpr_b_data = i_gpr_b_rd ? {11'h0, i_gpr_b_idx, 16'h0} : ~noise_q;
   assign o_fpr_data = !i_fpr_rd ? {noise_q, ~noise_q} :
      (i_fpr_idx == 5'h06) ? 64'h4865_6c6c_6f20_776f :
      (i_fpr_idx == 5'h07) ? 64'h37f0_0000_0000_0000 :
      {27'h0, i_fpr_idx, 27'h0, ~i_fpr_idx};
endmodule : store_port_model

// ### tb/testbench.sv
// Purpose: directed checks of the fp pair and single stores
// Assumes: register contents come from the partner model
// Notes:   stores and write-backs are logged at the clock edge
`timescale 1ns/1ps
module testbench;
   logic i_ref_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_instr_valid = 1'b0;
   logic [31:0] i_instr = 32'h0000_0000;
   logic [1:0] stall = 2'h0;
   logic i_st_ready, o_instr_ready, o_busy, o_done, o_unsupported;
   logic o_gpr_a_rd, o_gpr_b_rd, o_fpr_rd, o_gpr_we, o_st_valid, o_st_dword;
   logic [4:0] o_gpr_a_idx, o_gpr_b_idx, o_fpr_idx, o_gpr_w_idx;
   logic [31:0] i_gpr_a_data, i_gpr_b_data, o_gpr_w_data, o_st_addr;
   logic [63:0] i_fpr_data, o_st_data;
   logic [7:0] o_st_be;
   int miscompares = 0;
   int n_checks = 0;
   logic [104:0] st_q[$];
   logic [36:0] wb_q[$];
   always #25 i_ref_clk = ~i_ref_clk;
   fp_quad_single_store_exec fp_quad_single_store_exec_inst (.*);
   store_port_model store_port_model_inst (.i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst), .i_stall(stall), .i_gpr_a_rd(o_gpr_a_rd),
      .i_gpr_a_idx(o_gpr_a_idx), .i_gpr_b_rd(o_gpr_b_rd),
      .i_gpr_b_idx(o_gpr_b_idx), .i_fpr_rd(o_fpr_rd), .i_fpr_idx(o_fpr_idx),
      .o_gpr_a_data(i_gpr_a_data), .o_gpr_b_data(i_gpr_b_data),
      .o_fpr_data(i_fpr_data), .i_st_valid(o_st_valid),
      .o_st_ready(i_st_ready));
   always @(posedge i_ref_clk) begin
      if (o_st_valid && i_st_ready)
         st_q.push_back({o_st_addr, o_st_data, o_st_be, o_st_dword});
      if (o_gpr_we)
         wb_q.push_back({o_gpr_w_idx, o_gpr_w_data});
   end
   ///////////////////////////////////////////////////////////
   // helpers
   function automatic logic [63:0] fpv(input logic [4:0] i);
      return (i == 5'h06) ? 64'h4865_6c6c_6f20_776f :
         (i == 5'h07) ? 64'h37f0_0000_0000_0000 : {27'h0, i, 27'h0, ~i};
   endfunction : fpv
   task automatic close_out();
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   task automatic check(input string nm, input logic [127:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic go(input logic [31:0] ins, input logic [1:0] stl,
         input logic [31:0] ea, input int nst, input logic [37:0] wb);
      int k;
      logic u;
      logic [4:0] s;
      logic [31:0] sw;
      s = ins[25:21];
      sw = (s == 5'h07) ? 32'h0020_0000 : 32'h432b_6363;
      st_q.delete();
      wb_q.delete();
      @(negedge i_ref_clk);
      stall = stl;
      i_instr = ins;
      i_instr_valid = 1'b1;
      @(negedge i_ref_clk);
      i_instr_valid = 1'b0;
      check("busy", o_busy, nst != 0);
      for (k = 0; k < 60 && o_done !== 1'b1 && o_unsupported !== 1'b1; k++)
         @(negedge i_ref_clk);
      u = o_unsupported;
      if (k == 60) begin
         miscompares++;
         close_out();
      end
      @(negedge i_ref_clk);
      check("unsupported", u, nst == 0);
      check("store count", st_q.size(), nst);
      if (nst == 2 && st_q.size() == 2) begin
         check("addr0", st_q[0][104:73], ea);
         check("data0", st_q[0][72:0], {fpv(s), 9'h1ff});
         check("addr1", st_q[1][104:73], ea + 32'h0000_0008);
         check("data1", st_q[1][72:0], {fpv(s + 5'h01), 9'h1ff});
      end
      if (nst == 1 && st_q.size() == 1)
         check("word", st_q[0], {ea, sw, 41'h1e0});
      check("write-back count", wb_q.size(), wb[37]);
      if (wb[37] && wb_q.size() == 1)
         check("write-back", wb_q[0], wb[36:0]);
   endtask : go
   ///////////////////////////////////////////////////////////
   // scenarios
   task automatic s_pair_disp();
      go({6'h3c, 5'h1f, 5'h03, 14'h3ffe, 2'h0}, 2'h3, 32'h0002_fff8, 2,
         38'h0);
      go({6'h3c, 5'h02, 5'h00, 14'h1fff, 2'h0}, 2'h1, 32'h0000_7ffc, 2,
         38'h0);
   endtask : s_pair_disp
   task automatic s_pair_upd();
      go({6'h3d, 5'h04, 5'h07, 14'h0010, 2'h1}, 2'h0, 32'h0007_0040, 2,
         {1'h1, 5'h07, 32'h0007_0040});
      go({6'h3d, 5'h1e, 5'h00, 14'h2000, 2'h1}, 2'h2, 32'hffff_8000, 2,
         38'h0);
   endtask : s_pair_upd
   task automatic s_pair_idx();
      go({6'h1f, 5'h08, 5'h02, 5'h09, 10'h397, 1'h0}, 2'h0, 32'h000b_0000,
         2, 38'h0);
      go({6'h1f, 5'h0a, 5'h00, 5'h0c, 10'h3b7, 1'h1}, 2'h1, 32'h000c_0000,
         2, 38'h0);
      go({6'h1f, 5'h1f, 5'h05, 5'h01, 10'h3b7, 1'h0}, 2'h0, 32'h0006_0000,
         2, {1'h1, 5'h05, 32'h0006_0000});
   endtask : s_pair_idx
   task automatic s_single();
      go({6'h34, 5'h06, 5'h00, 16'hfff0}, 2'h2, 32'hffff_fff0, 1,
         38'h0);
      go({6'h34, 5'h06, 5'h04, 16'h8000}, 2'h0, 32'h0003_8000, 1,
         38'h0);
      go({6'h34, 5'h07, 5'h00, 16'h0010}, 2'h1, 32'h0000_0010, 1,
         38'h0);
   endtask : s_single
   task automatic s_unknown();
      go({6'h3c, 5'h01, 5'h02, 14'h0001, 2'h1}, 2'h0, 32'h0, 0,
         38'h0);
      go({6'h1f, 5'h01, 5'h02, 5'h03, 10'h2d7, 1'h0}, 2'h0, 32'h0, 0,
         38'h0);
   endtask : s_unknown
   initial begin
      repeat (12) @(negedge i_ref_clk);
      i_nrst = 1'b1;
      check("ready", o_instr_ready, 1'b1);
      s_pair_disp();
      s_pair_upd();
      s_pair_idx();
      s_single();
      s_unknown();
      close_out();
   end
endmodule : testbench
